/* File: include/ihp_pkg.sv */
// Summary of operation
// - trailing n pins are active low
// - select when address matches straps, enable low
// - low five address bits pick register
// - upper lane only while upper enable low
// - ready line undriven when not accessed
// - ready pulled low, released; host waits
// - cs16 pulled low for upper lane access
// - selected read drives addressed register data
// - selected write captured on strobe rising edge
// - reset holds port idle while asserted
// - mode strap caught at reset picks emulation
// - width sense low means 16-bit bus
// - drq asserted while dma transfer needed
// - dma acknowledge routes access to fifo
// - interrupt when any unmasked condition true
// - lane drive flags follow data drivers
// - data bus driven only during reads
// - serial key via strobe, data, reset
// - board supplies device oscillator clock
package ihp_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned MCLK_HZ         = 25_000_000;
  localparam int unsigned MCLK_MHZ        = MCLK_HZ / 1_000_000;
  localparam int unsigned KEY_HALF_NS     = 1000;
  localparam int unsigned KEY_HALF_CYC    = (KEY_HALF_NS * MCLK_MHZ + 999) / 1000;
  localparam int unsigned RDY_WAIT_CYC    = 2;
  localparam int unsigned HOST_STROBE_CYC = 3;
  localparam int unsigned KEY_BITS        = 8;
  ////////////////////////////////////////////////////////////////////////////
  // synchronised strap vector layout
  localparam int unsigned STRAP_W    = 8;
  localparam int unsigned S_KEY      = 0;
  localparam int unsigned S_WIDTH    = 1;
  localparam int unsigned S_MODE     = 2;
  localparam int unsigned S_BASE_LO  = 3;
  localparam int unsigned S_BASE_HI  = 7;
  ////////////////////////////////////////////////////////////////////////////
  // address fields
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned SEL_W      = 5;
  localparam int unsigned BASE_LO    = 5;
  localparam int unsigned BASE_HI    = 9;
  ////////////////////////////////////////////////////////////////////////////
  // modes and states
  typedef enum logic {IHP_MODE_SECOND, IHP_MODE_FIRST} ihp_mode_t;
  typedef enum logic [1:0] {K_IDLE, K_LOW, K_HIGH} ihp_key_st_t;
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_STRB, H_DONE} ihp_host_st_t;
endpackage : ihp_pkg

/* File: include/ihp_if.sv */
interface ihp_if;
  // host driven
  logic [9:0]  addr;
  logic        aen_n;
  logic        ior_n;
  logic        iow_n;
  logic        upper_lane_enable_n;
  logic        dack_n;
  logic [15:0] host_d_o;
  logic [1:0]  host_d_oe;
  // device driven
  logic [15:0] dev_d_o;
  logic [1:0]  dev_d_oe;
  logic        rdy_oe;
  logic        cs16_oe;
  logic        drq;
  logic        intr;
  logic        low_lane_drive_flag_n;
  logic        high_lane_drive_flag_n;
  // resolved lines, pull-ups when nobody drives
  logic [7:0]  host_data_low;
  logic [7:0]  host_data_high;
  logic        iochrdy;
  logic        iocs16_n;

  assign host_data_low  = dev_d_oe[0] ? dev_d_o[7:0] : (host_d_oe[0] ? host_d_o[7:0] : 8'hFF);
  assign host_data_high = dev_d_oe[1] ? dev_d_o[15:8] : (host_d_oe[1] ? host_d_o[15:8] : 8'hFF);
  assign iochrdy        = ~rdy_oe;
  assign iocs16_n       = ~cs16_oe;

  modport dev (
    input  addr, aen_n, ior_n, iow_n, upper_lane_enable_n, dack_n, host_data_low, host_data_high,
    output dev_d_o, dev_d_oe, rdy_oe, cs16_oe, drq, intr, low_lane_drive_flag_n, high_lane_drive_flag_n
  );
  modport host (
    input  host_data_low, host_data_high, iochrdy, iocs16_n, drq, intr,
    output addr, aen_n, ior_n, iow_n, upper_lane_enable_n, dack_n, host_d_o, host_d_oe
  );
endinterface : ihp_if

/* File: core/ihp_dev.sv */
module ihp_dev #(
  parameter int unsigned RDY_WAIT = ihp_pkg::RDY_WAIT_CYC,
  parameter int unsigned KEY_HALF = ihp_pkg::KEY_HALF_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // isa bus
  ihp_if.dev               bus,
  // straps
  input  wire logic [4:0]  base_address_straps,
  input  wire logic        mode_strap,
  input  wire logic        bus_width_sense_n,
  // register side
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [4:0]       reg_sel,
  output logic [15:0]      reg_wdata,
  output logic [1:0]       reg_be,
  input  wire logic [15:0] reg_rdata,
  // fifo side
  output logic             fifo_rd,
  output logic             fifo_wr,
  input  wire logic [15:0] fifo_rdata,
  input  wire logic        dma_need,
  // interrupt conditions
  input  wire logic [7:0]  irq_cond,
  input  wire logic [7:0]  irq_mask,
  // mode and width status
  output logic             emu_mode_first,
  output logic             bus_is_wide,
  // key command
  input  wire logic        key_start,
  input  wire logic        key_write,
  input  wire logic [7:0]  key_tx,
  output logic             key_busy,
  output logic             key_done,
  output logic [7:0]       key_rx,
  // key pins
  output logic             key_strobe_n,
  output logic             key_reset_n,
  output logic             key_serial_o,
  output logic             key_serial_oe,
  input  wire logic        key_serial_i
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [ihp_pkg::STRAP_W-1:0] s1;
    logic [ihp_pkg::STRAP_W-1:0] s2;
    logic                        mode;
    logic                        wide;
    logic                        ior_q;
    logic                        iow_q;
    logic                        wr_act;
    logic                        acc_dma;
    logic                        acc_hi;
    logic [4:0]                  acc_reg;
    logic [15:0]                 acc_data;
    logic [15:0]                 dout;
    logic [1:0]                  doe;
    logic                        lo_flag_n;
    logic                        hi_flag_n;
    logic                        rdy_oe;
    logic [7:0]                  rdy_cnt;
    logic                        cs16_oe;
    logic                        drq;
    logic                        intr;
    logic                        reg_rd;
    logic                        reg_wr;
    logic                        fifo_rd;
    logic                        fifo_wr;
    ihp_pkg::ihp_key_st_t        kst;
    logic                        kwr;
    logic [3:0]                  kbit;
    logic [15:0]                 kcnt;
    logic [7:0]                  ksh;
    logic                        kstb_n;
    logic                        krst_n;
    logic                        kio_o;
    logic                        kio_oe;
    logic                        kdone;
    logic                        kbusy;
  } ihp_dev_st_t;

  ihp_dev_st_t r_r;
  ihp_dev_st_t r_nxt;

  function automatic logic [7:0] ihp_cnt8(input int unsigned v);
    ihp_cnt8 = v[7:0];
  endfunction : ihp_cnt8

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic sel;
    logic dma;
    logic hit;
    logic hi;
    logic [15:0] rd_src;
    sel    = 1'b0;
    dma    = 1'b0;
    hit    = 1'b0;
    hi     = 1'b0;
    rd_src = 16'h0000;
    r_nxt  = r_r;
    // straps pass two flip-flops
    r_nxt.s1 = {base_address_straps, mode_strap, bus_width_sense_n, key_serial_i};
    r_nxt.s2 = r_r.s1;
    r_nxt.reg_rd  = 1'b0;
    r_nxt.reg_wr  = 1'b0;
    r_nxt.fifo_rd = 1'b0;
    r_nxt.fifo_wr = 1'b0;
    r_nxt.kdone   = 1'b0;

    sel = ~bus.aen_n
          && (bus.addr[ihp_pkg::BASE_HI:ihp_pkg::BASE_LO]
              == r_r.s2[ihp_pkg::S_BASE_HI:ihp_pkg::S_BASE_LO]);
    dma = ~bus.dack_n;
    hit = sel | dma;
    hi  = r_r.wide & ~bus.upper_lane_enable_n;
    rd_src = r_r.acc_dma ? fifo_rdata : reg_rdata;

    r_nxt.wide  = ~r_r.s2[ihp_pkg::S_WIDTH];
    r_nxt.ior_q = bus.ior_n;
    r_nxt.iow_q = bus.iow_n;
    r_nxt.drq   = dma_need;
    r_nxt.intr  = |(irq_cond & ~irq_mask);
    r_nxt.cs16_oe = hit & hi & (~bus.ior_n | ~bus.iow_n);

    // read: pull ready low, fetch, then drive and release
    if (~bus.ior_n && r_r.ior_q && hit) begin
      r_nxt.acc_dma = dma;
      r_nxt.acc_hi  = hi;
      r_nxt.acc_reg = bus.addr[ihp_pkg::SEL_W-1:0];
      r_nxt.reg_rd  = ~dma;
      r_nxt.fifo_rd = dma;
      r_nxt.rdy_oe  = 1'b1;
      r_nxt.rdy_cnt = ihp_cnt8(RDY_WAIT);
    end else if (r_r.rdy_oe) begin
      if (bus.ior_n) begin
        r_nxt.rdy_oe = 1'b0;
      end else if (r_r.rdy_cnt <= 8'h01) begin
        r_nxt.dout   = rd_src;
        r_nxt.doe    = {r_r.acc_hi, 1'b1};
        r_nxt.rdy_oe = 1'b0;
      end else begin
        r_nxt.rdy_cnt = r_r.rdy_cnt - 8'h01;
      end
    end
    if (bus.ior_n) begin
      r_nxt.doe = 2'b00;
    end

    // write: hold last low-phase data, commit on rising edge
    if (~bus.iow_n && hit) begin
      r_nxt.wr_act   = 1'b1;
      r_nxt.acc_dma  = dma;
      r_nxt.acc_hi   = hi;
      r_nxt.acc_reg  = bus.addr[ihp_pkg::SEL_W-1:0];
      r_nxt.acc_data = {hi ? bus.host_data_high : 8'h00, bus.host_data_low};
    end else if (bus.iow_n && ~r_r.iow_q && r_r.wr_act) begin
      r_nxt.wr_act  = 1'b0;
      r_nxt.reg_wr  = ~r_r.acc_dma;
      r_nxt.fifo_wr = r_r.acc_dma;
    end else if (bus.iow_n) begin
      r_nxt.wr_act = 1'b0;
    end

    r_nxt.lo_flag_n = ~r_nxt.doe[0];
    r_nxt.hi_flag_n = ~r_nxt.doe[1];

    // serial key engine
    case (r_r.kst)
      ihp_pkg::K_IDLE: begin
        if (key_start) begin
          r_nxt.kst    = ihp_pkg::K_LOW;
          r_nxt.kwr    = key_write;
          r_nxt.ksh    = key_tx;
          r_nxt.kbit   = 4'h0;
          r_nxt.kbusy  = 1'b1;
          r_nxt.kcnt   = 16'(KEY_HALF);
          r_nxt.krst_n = 1'b1;
          r_nxt.kstb_n = 1'b0;
          r_nxt.kio_oe = key_write;
          r_nxt.kio_o  = key_tx[0];
        end
      end
      ihp_pkg::K_LOW: begin
        if (r_r.kcnt <= 16'h0001) begin
          r_nxt.kst    = ihp_pkg::K_HIGH;
          r_nxt.kcnt   = 16'(KEY_HALF);
          r_nxt.kstb_n = 1'b1;
          r_nxt.ksh    = {r_r.kwr ? r_r.ksh[0] : r_r.s2[ihp_pkg::S_KEY], r_r.ksh[7:1]};
        end else begin
          r_nxt.kcnt = r_r.kcnt - 16'h0001;
        end
      end
      ihp_pkg::K_HIGH: begin
        if (r_r.kcnt > 16'h0001) begin
          r_nxt.kcnt = r_r.kcnt - 16'h0001;
        end else if (r_r.kbit == 4'(ihp_pkg::KEY_BITS - 1)) begin
          r_nxt.kst    = ihp_pkg::K_IDLE;
          r_nxt.kbusy  = 1'b0;
          r_nxt.kio_oe = 1'b0;
          r_nxt.krst_n = 1'b0;
          r_nxt.kdone  = 1'b1;
        end else begin
          r_nxt.kst    = ihp_pkg::K_LOW;
          r_nxt.kbit   = r_r.kbit + 4'h1;
          r_nxt.kcnt   = 16'(KEY_HALF);
          r_nxt.kstb_n = 1'b0;
          r_nxt.kio_o  = r_r.ksh[0];
        end
      end
      default: begin
        r_nxt.kst = ihp_pkg::K_IDLE;
      end
    endcase

    // reset holds everything idle, mode strap caught meanwhile
    if (rst) begin
      r_nxt           = '0;
      r_nxt.s1        = {base_address_straps, mode_strap, bus_width_sense_n, key_serial_i};
      r_nxt.s2        = r_r.s1;
      r_nxt.mode      = r_r.s2[ihp_pkg::S_MODE];
      r_nxt.ior_q     = 1'b1;
      r_nxt.iow_q     = 1'b1;
      r_nxt.lo_flag_n = 1'b1;
      r_nxt.hi_flag_n = 1'b1;
      r_nxt.kstb_n    = 1'b1;
      r_nxt.kst       = ihp_pkg::K_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk) begin
    r_r <= r_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign bus.dev_d_o                = r_r.dout;
  assign bus.dev_d_oe               = r_r.doe;
  assign bus.rdy_oe                 = r_r.rdy_oe;
  assign bus.cs16_oe                = r_r.cs16_oe;
  assign bus.drq                    = r_r.drq;
  assign bus.intr                   = r_r.intr;
  assign bus.low_lane_drive_flag_n  = r_r.lo_flag_n;
  assign bus.high_lane_drive_flag_n = r_r.hi_flag_n;
  assign reg_rd                     = r_r.reg_rd;
  assign reg_wr                     = r_r.reg_wr;
  assign reg_sel                    = r_r.acc_reg;
  assign reg_wdata                  = r_r.acc_data;
  assign reg_be                     = {r_r.acc_hi, 1'b1};
  assign fifo_rd                    = r_r.fifo_rd;
  assign fifo_wr                    = r_r.fifo_wr;
  assign emu_mode_first             = r_r.mode;
  assign bus_is_wide                = r_r.wide;
  assign key_busy                   = r_r.kbusy;
  assign key_done                   = r_r.kdone;
  assign key_rx                     = r_r.ksh;
  assign key_strobe_n               = r_r.kstb_n;
  assign key_reset_n                = r_r.krst_n;
  assign key_serial_o               = r_r.kio_o;
  assign key_serial_oe              = r_r.kio_oe;
endmodule : ihp_dev

/* File: core/ihp_host.sv */
module ihp_host #(
  parameter int unsigned STROBE = ihp_pkg::HOST_STROBE_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // isa bus
  ihp_if.host              bus,
  // command
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_dma,
  input  wire logic        cmd_upper,
  input  wire logic [9:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_ready,
  // response
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_cs16,
  // device requests
  output logic             drq,
  output logic             intr
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    ihp_pkg::ihp_host_st_t st;
    logic                  wr;
    logic [7:0]            cnt;
    logic [9:0]            addr;
    logic                  aen_n;
    logic                  ior_n;
    logic                  iow_n;
    logic                  bhe_n;
    logic                  dack_n;
    logic [15:0]           dout;
    logic [1:0]            doe;
    logic                  ready;
    logic                  rsp;
    logic [15:0]           rdata;
    logic                  cs16;
    logic                  drq;
    logic                  intr;
  } ihp_host_state_t;

  ihp_host_state_t r_r;
  ihp_host_state_t r_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_nxt      = r_r;
    r_nxt.rsp  = 1'b0;
    r_nxt.drq  = bus.drq;
    r_nxt.intr = bus.intr;
    case (r_r.st)
      ihp_pkg::H_IDLE: begin
        if (cmd_valid) begin
          r_nxt.st     = ihp_pkg::H_ADDR;
          r_nxt.ready  = 1'b0;
          r_nxt.wr     = cmd_write;
          r_nxt.addr   = cmd_addr;
          r_nxt.aen_n  = cmd_dma;
          r_nxt.dack_n = ~cmd_dma;
          r_nxt.bhe_n  = ~cmd_upper;
          r_nxt.dout   = cmd_wdata;
        end
      end
      ihp_pkg::H_ADDR: begin
        r_nxt.st    = ihp_pkg::H_STRB;
        r_nxt.cnt   = STROBE[7:0];
        r_nxt.ior_n = r_r.wr;
        r_nxt.iow_n = ~r_r.wr;
        r_nxt.doe   = r_r.wr ? {~r_r.bhe_n, 1'b1} : 2'b00;
      end
      ihp_pkg::H_STRB: begin
        r_nxt.cs16 = r_r.cs16 | ~bus.iocs16_n;
        if (r_r.cnt > 8'h01) begin
          r_nxt.cnt = r_r.cnt - 8'h01;
        end else if (bus.iochrdy) begin
          r_nxt.st    = ihp_pkg::H_DONE;
          r_nxt.rdata = {bus.host_data_high, bus.host_data_low};
          r_nxt.ior_n = 1'b1;
          r_nxt.iow_n = 1'b1;
        end
      end
      ihp_pkg::H_DONE: begin
        r_nxt.st     = ihp_pkg::H_IDLE;
        r_nxt.doe    = 2'b00;
        r_nxt.aen_n  = 1'b1;
        r_nxt.dack_n = 1'b1;
        r_nxt.bhe_n  = 1'b1;
        r_nxt.rsp    = 1'b1;
        r_nxt.ready  = 1'b1;
      end
      default: begin
        r_nxt.st = ihp_pkg::H_IDLE;
      end
    endcase
    if (r_r.st == ihp_pkg::H_IDLE && cmd_valid) begin
      r_nxt.cs16 = 1'b0;
    end
    if (rst) begin
      r_nxt        = '0;
      r_nxt.st     = ihp_pkg::H_IDLE;
      r_nxt.aen_n  = 1'b1;
      r_nxt.ior_n  = 1'b1;
      r_nxt.iow_n  = 1'b1;
      r_nxt.bhe_n  = 1'b1;
      r_nxt.dack_n = 1'b1;
      r_nxt.ready  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk) begin
    r_r <= r_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign bus.addr                = r_r.addr;
  assign bus.aen_n               = r_r.aen_n;
  assign bus.ior_n               = r_r.ior_n;
  assign bus.iow_n               = r_r.iow_n;
  assign bus.upper_lane_enable_n = r_r.bhe_n;
  assign bus.dack_n              = r_r.dack_n;
  assign bus.host_d_o            = r_r.dout;
  assign bus.host_d_oe           = r_r.doe;
  assign cmd_ready               = r_r.ready;
  assign rsp_valid               = r_r.rsp;
  assign rsp_rdata               = r_r.rdata;
  assign rsp_cs16                = r_r.cs16;
  assign drq                     = r_r.drq;
  assign intr                    = r_r.intr;
endmodule : ihp_host

/* File: testbench/ihp_monitor.sv */
module ihp_monitor #(
  parameter logic [4:0] BASE = 5'h0A
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // host driven
  input wire logic [9:0]  addr,
  input wire logic        aen_n,
  input wire logic        ior_n,
  input wire logic        iow_n,
  input wire logic        upper_lane_enable_n,
  input wire logic        dack_n,
  input wire logic [1:0]  host_d_oe,
  // device driven
  input wire logic [1:0]  dev_d_oe,
  input wire logic        rdy_oe,
  input wire logic        cs16_oe,
  input wire logic        low_lane_drive_flag_n,
  input wire logic        high_lane_drive_flag_n,
  // resolved
  input wire logic        iochrdy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // read starts
  sequence s_hit_rd;
    $fell(ior_n) && ((!aen_n && addr[9:5] == BASE) || !dack_n);
  endsequence
  sequence s_miss_rd;
    $fell(ior_n) && dack_n && (aen_n || addr[9:5] != BASE);
  endsequence
  sequence s_wait_then_drive;
    rdy_oe [*2] ##1 (!rdy_oe && dev_d_oe[0]);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // properties
  property p_read_wait;   s_hit_rd |=> s_wait_then_drive; endproperty
  property p_miss;        s_miss_rd |=> (!rdy_oe && dev_d_oe == 2'b00) [*4]; endproperty
  property p_idle_rdy;    ior_n && $past(ior_n) |-> !rdy_oe; endproperty
  property p_host_wait;   !iochrdy && !ior_n |=> !ior_n; endproperty
  property p_flag_lo;     low_lane_drive_flag_n == !dev_d_oe[0]; endproperty
  property p_flag_hi;     high_lane_drive_flag_n == !dev_d_oe[1]; endproperty
  property p_drive_read;  dev_d_oe != 2'b00 |-> $past(!ior_n); endproperty
  property p_upper;       dev_d_oe[1] |-> !upper_lane_enable_n; endproperty
  property p_cs16;        cs16_oe |-> $past(!upper_lane_enable_n && (!ior_n || !iow_n)); endproperty
  property p_no_clash;    (dev_d_oe & host_d_oe) == 2'b00; endproperty
  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_read_wait:  assert property (p_read_wait)  else $error("read wait sequence wrong");
  a_miss:       assert property (p_miss)       else $error("unselected read answered");
  a_idle_rdy:   assert property (p_idle_rdy)   else $error("ready held without read");
  a_host_wait:  assert property (p_host_wait)  else $error("host ended cycle early");
  a_flag_lo:    assert property (p_flag_lo)    else $error("low lane flag wrong");
  a_flag_hi:    assert property (p_flag_hi)    else $error("high lane flag wrong");
  a_drive_read: assert property (p_drive_read) else $error("data driven outside read");
  a_upper:      assert property (p_upper)      else $error("upper lane without enable");
  a_cs16:       assert property (p_cs16)       else $error("cs16 without upper access");
  a_no_clash:   assert property (p_no_clash)   else $error("data bus contention");
endmodule : ihp_monitor

/* File: testbench/test_isa_host_bus_port.sv */
module test_isa_host_bus_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] BASE = 5'h0A;
  logic        mclk, rst, mode_strap, bus_width_sense_n, reg_rd, reg_wr, fifo_rd, fifo_wr, dma_need;
  logic        emu_first, wide, key_start, key_busy, key_done, key_strobe_n, key_reset_n, key_so, key_soe;
  logic        cmd_valid, cmd_write, cmd_dma, cmd_upper, cmd_ready, rsp_valid, rsp_cs16, h_drq, h_intr;
  logic        key_wr, key_prev;
  logic [4:0]  reg_sel, w_sel;
  logic [15:0] reg_wdata, fifo_word, rsp_rdata, cmd_wdata, w_data;
  logic [1:0]  reg_be, w_be;
  logic [7:0]  irq_cond, irq_mask, key_rx, key_tx, key_seen;
  logic [9:0]  cmd_addr;
  int          bad_count, comparisons, cyc, wr_n, frd_n, fwr_n, rrd_n;
  ////////////////////////////////////////////////////////////////////////////
  // design and checker
  ihp_if bus_if ();
  ihp_dev #(.RDY_WAIT(2), .KEY_HALF(2)) ihp_dev_i (.mclk(mclk), .rst(rst), .bus(bus_if),
    .base_address_straps(BASE), .mode_strap(mode_strap), .bus_width_sense_n(bus_width_sense_n),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_be(reg_be),
    .reg_rdata(rd_val(reg_sel)), .fifo_rd(fifo_rd), .fifo_wr(fifo_wr), .fifo_rdata(fifo_word),
    .dma_need(dma_need), .irq_cond(irq_cond), .irq_mask(irq_mask), .emu_mode_first(emu_first),
    .bus_is_wide(wide), .key_start(key_start), .key_write(key_wr), .key_tx(key_tx), .key_busy(key_busy),
    .key_done(key_done), .key_rx(key_rx), .key_strobe_n(key_strobe_n), .key_reset_n(key_reset_n),
    .key_serial_o(key_so), .key_serial_oe(key_soe), .key_serial_i(key_soe ? key_so : 1'b1));
  ihp_host #(.STROBE(3)) ihp_host_i (.mclk(mclk), .rst(rst), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_dma(cmd_dma), .cmd_upper(cmd_upper), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_cs16(rsp_cs16), .drq(h_drq), .intr(h_intr));
  ihp_monitor #(.BASE(BASE)) ihp_monitor_i (.mclk(mclk), .rst(rst), .addr(bus_if.addr),
    .aen_n(bus_if.aen_n), .ior_n(bus_if.ior_n), .iow_n(bus_if.iow_n),
    .upper_lane_enable_n(bus_if.upper_lane_enable_n), .dack_n(bus_if.dack_n), .host_d_oe(bus_if.host_d_oe),
    .dev_d_oe(bus_if.dev_d_oe), .rdy_oe(bus_if.rdy_oe), .cs16_oe(bus_if.cs16_oe),
    .low_lane_drive_flag_n(bus_if.low_lane_drive_flag_n),
    .high_lane_drive_flag_n(bus_if.high_lane_drive_flag_n), .iochrdy(bus_if.iochrdy));
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] rd_val(input logic [4:0] s);
    return {3'b101, s, ~s, 3'b010};
  endfunction : rd_val

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic host_op(input logic w, input logic d, input logic u, input logic [9:0] a,
                         input logic [15:0] wd);
    int n;
    @(negedge mclk);
    cmd_valid = 1;
    cmd_write = w;
    cmd_dma   = d;
    cmd_upper = u;
    cmd_addr  = a;
    cmd_wdata = wd;
    @(negedge mclk);
    cmd_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    check({15'd0, rsp_valid}, 16'd1);
    repeat (3) @(negedge mclk);
  endtask : host_op

  task automatic do_reset(input logic m, input logic wn);
    @(negedge mclk);
    rst = 1;
    mode_strap = m;
    bus_width_sense_n = wn;
    repeat (8) @(negedge mclk);
    check({14'd0, bus_if.dev_d_oe}, 16'd0);
    check({15'd0, bus_if.rdy_oe}, 16'd0);
    rst = 0;
    repeat (4) @(negedge mclk);
    check({15'd0, emu_first}, {15'd0, m});
    check({15'd0, wide}, {15'd0, ~wn});
    $display("test reset done");
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  // clock, pulse counters, timeout
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (reg_wr === 1'b1) begin
      wr_n++;
      w_sel = reg_sel;
      w_data = reg_wdata;
      w_be = reg_be;
    end
    if (fifo_rd === 1'b1) frd_n++;
    if (reg_rd === 1'b1) rrd_n++;
    if (key_prev === 1'b1 && key_strobe_n === 1'b0) key_seen = {key_so, key_seen[7:1]};
    key_prev = key_strobe_n;
    if (fifo_wr === 1'b1) fwr_n++;
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    logic w, u;
    logic [4:0] s;
    logic [15:0] wd, exp;
    int k0, k1, k2;
    {rst, mode_strap, bus_width_sense_n, cmd_valid, cmd_write, cmd_dma, cmd_upper} = 7'b1100000;
    {cmd_addr, cmd_wdata, dma_need, irq_cond, irq_mask, key_start, key_wr, key_tx} = '0;
    fifo_word = 16'h5AC3;
    {bad_count, comparisons, cyc, wr_n, frd_n, fwr_n, rrd_n} = '0;
    void'($urandom(46891));
    do_reset(1, 0);
    for (int i = 0; i < 24; i++) begin
      s = (i < 2) ? 5'(i * 31) : 5'($urandom);
      u = (i < 4) ? i[0] : 1'($urandom);
      w = (i < 4) ? i[1] : 1'($urandom);
      wd = 16'($urandom);
      k0 = wr_n;
      k1 = rrd_n;
      host_op(w, 0, u, {BASE, s}, wd);
      exp = rd_val(s);
      if (w) begin
        check(16'(wr_n - k0), 16'd1);
        check({11'd0, w_sel}, {11'd0, s});
        check(w_data, {u ? wd[15:8] : 8'h00, wd[7:0]});
        check({14'd0, w_be}, {14'd0, u, 1'b1});
      end else begin
        check(rsp_rdata, {u ? exp[15:8] : 8'hFF, exp[7:0]});
        check(16'(rrd_n - k1), 16'd1);
      end
      check({15'd0, rsp_cs16}, {15'd0, u});
    end
    $display("test register access done");
    k0 = wr_n;
    k1 = rrd_n;
    host_op(1, 0, 1, {~BASE, 5'd3}, 16'h1234);
    host_op(0, 0, 1, {BASE ^ 5'd1, 5'd3}, 16'h0000);
    check(rsp_rdata, 16'hFFFF);
    check(16'(wr_n - k0), 16'd0);
    check(16'(rrd_n - k1), 16'd0);
    $display("test unselected done");
    k0 = wr_n;
    k1 = frd_n;
    k2 = fwr_n;
    fifo_word = 16'($urandom);
    host_op(0, 1, 1, 10'd0, 16'h0000);
    check(rsp_rdata, fifo_word);
    host_op(1, 1, 1, 10'd0, 16'hBEEF);
    check(16'(frd_n - k1), 16'd1);
    check(16'(fwr_n - k2), 16'd1);
    check(16'(wr_n - k0), 16'd0);
    $display("test dma done");
    for (int i = 0; i < 10; i++) begin
      irq_cond = 8'($urandom);
      irq_mask = (i < 2) ? {8{~i[0]}} : 8'($urandom);
      dma_need = i[0];
      repeat (3) @(negedge mclk);
      check({15'd0, bus_if.intr}, {15'd0, |(irq_cond & ~irq_mask)});
      check({15'd0, bus_if.drq}, {15'd0, dma_need});
      check({15'd0, h_intr}, {15'd0, |(irq_cond & ~irq_mask)});
      check({15'd0, h_drq}, {15'd0, dma_need});
    end
    $display("test interrupt and request done");
    @(negedge mclk);
    key_start = 1;
    @(negedge mclk);
    key_start = 0;
    @(negedge mclk);
    check({15'd0, key_reset_n}, 16'd1);
    check({15'd0, key_busy}, 16'd1);
    k0 = 0;
    while (key_done !== 1'b1 && k0 < 200) begin
      @(negedge mclk);
      k0++;
    end
    check({15'd0, key_done}, 16'd1);
    check({8'd0, key_rx}, 16'h00FF);
    key_tx = 8'($urandom);
    key_wr = 1;
    @(negedge mclk);
    key_start = 1;
    @(negedge mclk);
    key_start = 0;
    @(negedge mclk);
    check({15'd0, key_soe}, 16'd1);
    repeat (40) @(negedge mclk);
    check({8'd0, key_seen}, {8'd0, key_tx});
    check({15'd0, key_busy}, 16'd0);
    $display("test key done");
    do_reset(0, 1);
    host_op(0, 0, 1, {BASE, 5'd6}, 16'h0000);
    exp = rd_val(5'd6);
    check(rsp_rdata, {8'hFF, exp[7:0]});
    check({15'd0, rsp_cs16}, 16'd0);
    $display("test narrow bus done");
    report_and_stop();
  end
endmodule : test_isa_host_bus_port
